// *** inc/rnv_pkg.sv ***
`default_nettype none

package rnv_pkg;

	// Widths of the datapath, the vector buses and the register address, and the register count
	localparam int XLEN      = 32;
	localparam int VEC_W     = 31;
	localparam int GPR_COUNT = 31;
	localparam int GPR_AW    = 5;

	// Cause codes reported for each kind of NMI, and reset values
	localparam logic [XLEN-1:0] CAUSE_NMI_PIN   = 32'h0000_0000;
	localparam logic [XLEN-1:0] CAUSE_DBUS_ST   = 32'hf000_0000;
	localparam logic [XLEN-1:0] CAUSE_DBUS_LD   = 32'hf000_0001;
	localparam logic [XLEN-1:0] CAUSE_RST_VAL   = 32'h0000_0000;
	localparam logic [XLEN-1:0] ERR_ADDR_RST    = 32'h0000_0000;
	localparam logic [XLEN-1:0] GPR_RST_VAL     = 32'h0000_0000;

	// Pin timing, in core clock cycles, and the width of its counter
	localparam int NMI_MIN_HIGH_CYC = 2;
	localparam int NMI_MIN_LOW_CYC  = 2;
	localparam int NMI_CNT_W        = 4;

	// Default vectors driven by the SoC end after reset
	localparam logic [VEC_W-1:0] BOOT_VEC_DEF = 31'h0000_0000;
	localparam logic [VEC_W-1:0] NMI_VEC_DEF  = 31'h0000_0000;

	// SoC-side pin sequencer, Gray coded along idle, high, low
	typedef enum logic [1:0]
	{
		RNV_PIN_IDLE = 2'h0,
		RNV_PIN_HIGH = 2'h1,
		RNV_PIN_LOW  = 2'h3
	} rnv_pin_e;

endpackage : rnv_pkg

`default_nettype wire

// *** inc/rnv_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none

// Wires between SoC logic and the core: reset, vectors and NMI pin
interface rnv_link_if;
	import rnv_pkg::*;

	logic             core_reset_n;
	logic [VEC_W-1:0] boot_vec;
	logic [VEC_W-1:0] nmi_vec;
	logic             nmi_pin;

	// SoC end drives everything
	modport soc
	(
		output core_reset_n,
		output boot_vec,
		output nmi_vec,
		output nmi_pin
	);

	// Core end only listens
	modport core
	(
		input core_reset_n,
		input boot_vec,
		input nmi_vec,
		input nmi_pin
	);

endinterface : rnv_link_if

`default_nettype wire

// *** verilog/rnv_soc_end.sv ***
`timescale 1ns/1ps
`default_nettype none

module rnv_soc_end
	import rnv_pkg::*;
#(
	parameter logic [VEC_W-1:0] BOOT_VEC_RST = BOOT_VEC_DEF,
	parameter logic [VEC_W-1:0] NMI_VEC_RST  = NMI_VEC_DEF,
	parameter bit               USE_NMI_PIN  = 1'b1,
	parameter int               HIGH_CYC     = NMI_MIN_HIGH_CYC,
	parameter int               LOW_CYC      = NMI_MIN_LOW_CYC
)
(
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             resetn,
	// Link toward the core
	rnv_link_if.soc               link,
	// Vector registers
	input  wire logic             boot_vec_wr,
	input  wire logic             nmi_vec_wr,
	input  wire logic [VEC_W-1:0] vec_wdata,
	// NMI request
	input  wire logic             nmi_fire,
	output logic                  nmi_busy
);

	// Pulse shape must meet the core's synchroniser
	if (HIGH_CYC < NMI_MIN_HIGH_CYC || LOW_CYC < NMI_MIN_LOW_CYC
		|| HIGH_CYC > (1 << NMI_CNT_W) || LOW_CYC > (1 << NMI_CNT_W))
	begin : g_bad_timing
		$error("rnv_soc_end: pin pulse timing out of range");
	end

	localparam logic [NMI_CNT_W-1:0] HIGH_LOAD = NMI_CNT_W'(HIGH_CYC - 1);
	localparam logic [NMI_CNT_W-1:0] LOW_LOAD  = NMI_CNT_W'(LOW_CYC - 1);

	logic                 rst_s1_r;
	logic                 rst_s2_r;
	logic [VEC_W-1:0]     boot_vec_r;
	logic [VEC_W-1:0]     nmi_vec_r;
	rnv_pin_e             pin_state_r;
	logic [NMI_CNT_W-1:0] pin_cnt_r;
	logic                 pin_r;
	logic                 busy_r;

	// Core reset: asserts at once, releases on a clock edge
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rst_s1_r <= 1'b0;
			rst_s2_r <= 1'b0;
		end
		else
		begin
			rst_s1_r <= 1'b1;
			rst_s2_r <= rst_s1_r;
		end
	end

	// Vector registers, reset to the build defaults
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			boot_vec_r <= BOOT_VEC_RST;
			nmi_vec_r  <= NMI_VEC_RST;
		end
		else
		begin
			if (boot_vec_wr)
				boot_vec_r <= vec_wdata;
			if (nmi_vec_wr)
				nmi_vec_r <= vec_wdata;
		end
	end

	// Pin pulse: high then low for fixed counts; requests while busy are dropped
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pin_state_r <= RNV_PIN_IDLE;
			pin_cnt_r   <= '0;
			pin_r       <= 1'b0;
			busy_r      <= 1'b0;
		end
		else
		begin
			case (pin_state_r)
				RNV_PIN_IDLE:
				begin
					if (nmi_fire && USE_NMI_PIN)
					begin
						pin_state_r <= RNV_PIN_HIGH;
						pin_cnt_r   <= HIGH_LOAD;
						pin_r       <= 1'b1;
						busy_r      <= 1'b1;
					end
				end
				RNV_PIN_HIGH:
				begin
					if (pin_cnt_r == '0)
					begin
						pin_state_r <= RNV_PIN_LOW;
						pin_cnt_r   <= LOW_LOAD;
						pin_r       <= 1'b0;
					end
					else
						pin_cnt_r <= pin_cnt_r - 1'b1;
				end
				RNV_PIN_LOW:
				begin
					if (pin_cnt_r == '0)
					begin
						pin_state_r <= RNV_PIN_IDLE;
						busy_r      <= 1'b0;
					end
					else
						pin_cnt_r <= pin_cnt_r - 1'b1;
				end
				default:
				begin
					pin_state_r <= RNV_PIN_IDLE;
					pin_r       <= 1'b0;
					busy_r      <= 1'b0;
				end
			endcase
		end
	end

	// Unused pin stays at 0 because the sequencer never leaves idle
	assign link.core_reset_n = rst_s2_r;
	assign link.boot_vec     = boot_vec_r;
	assign link.nmi_vec      = nmi_vec_r;
	assign link.nmi_pin      = pin_r;
	assign nmi_busy          = busy_r;

endmodule : rnv_soc_end

`default_nettype wire

// *** verilog/rnv_core_end.sv ***
// Notes on behaviour
// - SoC drives 31-bit reset vector, bits 31:1.
// - Reset asserts asynchronously, releases on clock edge.
// - First fetch after reset uses reset vector.
// - Reset vector must point at fetchable memory.
// - Reset clears general registers x1 to x31.
// - SoC drives 31-bit NMI vector, bits 31:1.
// - NMI ignores ordinary interrupt mode entirely.
// - NMI pin synchronised; each rising edge fires.
// - SoC holds NMI pin high two cycles.
// - SoC holds pin low two cycles between.
// - Unused NMI pin tied to zero.
// - Data-bus store or nonblocking load error raises NMI.
// - Every NMI fetches from the NMI vector.
// - Pin NMI reports cause 0x0000_0000.
// - Store error NMI reports cause 0xF000_0000.
// - Load error NMI reports cause 0xF000_0001.
// - First error address captured, locks; later errors gated.
// - Lock released by reset or unlock write.
`timescale 1ns/1ps
`default_nettype none

module rnv_core_end
	import rnv_pkg::*;
#(
	parameter int GPR_W = XLEN
)
(
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              resetn,
	// Link from the SoC
	rnv_link_if.core               link,
	// Data-bus error reports
	input  wire logic              dbus_store_err,
	input  wire logic              dbus_load_err,
	input  wire logic [XLEN-1:0]   dbus_err_addr,
	input  wire logic              err_unlock_wr,
	// General register file
	input  wire logic              gpr_we,
	input  wire logic [GPR_AW-1:0] gpr_waddr,
	input  wire logic [GPR_W-1:0]  gpr_wdata,
	input  wire logic [GPR_AW-1:0] gpr_raddr,
	output logic      [GPR_W-1:0]  gpr_rdata,
	// Fetch redirect
	output logic                   fetch_valid,
	output logic      [XLEN-1:0]   fetch_addr,
	// NMI report
	output logic                   nmi_taken,
	output logic      [XLEN-1:0]   nmi_cause,
	output logic      [XLEN-1:0]   err_addr_capt,
	output logic                   err_locked
);

	// Registers must hold at least the full datapath width
	if (GPR_W < XLEN)
	begin : g_bad_width
		$error("rnv_core_end: GPR_W below datapath width");
	end

	logic             rst_n;
	logic             pin_s1_r;
	logic             pin_s2_r;
	logic             pin_d_r;
	logic             pin_rise;
	logic             pin_pend_r;
	logic             st_pend_r;
	logic             ld_pend_r;
	logic             boot_pend_r;
	logic             lock_r;
	logic             err_accept;
	logic             take_boot;
	logic             take_pin;
	logic             take_st;
	logic             take_ld;
	logic             take_nmi;
	logic             fetch_valid_r;
	logic [XLEN-1:0]  fetch_addr_r;
	logic             nmi_taken_r;
	logic [XLEN-1:0]  nmi_cause_r;
	logic [XLEN-1:0]  err_addr_r;
	logic [GPR_W-1:0] gpr_rdata_r;
	logic [GPR_W-1:0] gpr_r [0:GPR_COUNT];

	// Both resets assert at once and release on a clock edge,
	// so their AND keeps the same shape
	assign rst_n = resetn & link.core_reset_n;

	// Pin comes from another domain: two flops before any logic
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_s1_r <= 1'b0;
			pin_s2_r <= 1'b0;
			pin_d_r  <= 1'b0;
		end
		else
		begin
			pin_s1_r <= link.nmi_pin;
			pin_s2_r <= pin_s1_r;
			pin_d_r  <= pin_s2_r;
		end
	end

	// Edge detect on the second stage only; a level held high fires once
	assign pin_rise = pin_s2_r & ~pin_d_r;

	// Errors arriving while locked are dropped; pin NMIs are not
	assign err_accept = (dbus_store_err | dbus_load_err) & ~lock_r;

	// Boot fetch first, then pin, then store, then load
	assign take_boot = boot_pend_r;
	assign take_pin  = ~boot_pend_r & pin_pend_r;
	assign take_st   = ~boot_pend_r & ~pin_pend_r & st_pend_r;
	assign take_ld   = ~boot_pend_r & ~pin_pend_r & ~st_pend_r & ld_pend_r;
	assign take_nmi  = take_pin | take_st | take_ld;

	// Boot fetch is owed once after every reset release
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			boot_pend_r <= 1'b1;
		else
			boot_pend_r <= 1'b0;
	end

	// Pending NMI sources; a new event wins over the clear of its take
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_pend_r <= 1'b0;
			st_pend_r  <= 1'b0;
			ld_pend_r  <= 1'b0;
		end
		else
		begin
			pin_pend_r <= pin_rise | (pin_pend_r & ~take_pin);
			st_pend_r  <= (err_accept & dbus_store_err) | (st_pend_r & ~take_st);
			ld_pend_r  <= (err_accept & ~dbus_store_err) | (ld_pend_r & ~take_ld);
		end
	end

	// Error lock: an error sets it only while unlocked; while locked, an unlock wins and an error in the same cycle is dropped
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			lock_r <= 1'b0;
		else if (err_accept)
			lock_r <= 1'b1;
		else if (err_unlock_wr)
			lock_r <= 1'b0;
	end

	// Address of the first unlocked error; held until next capture
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			err_addr_r <= ERR_ADDR_RST;
		else if (err_accept)
			err_addr_r <= dbus_err_addr;
	end

	// Fetch redirect; no interrupt mode input reaches this path
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fetch_valid_r <= 1'b0;
			fetch_addr_r  <= '0;
		end
		else
		begin
			fetch_valid_r <= take_boot | take_nmi;
			if (take_boot)
				fetch_addr_r <= {link.boot_vec, 1'b0};
			else if (take_nmi)
				fetch_addr_r <= {link.nmi_vec, 1'b0};
		end
	end

	// Cause code, held until the next NMI
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			nmi_taken_r <= 1'b0;
			nmi_cause_r <= CAUSE_RST_VAL;
		end
		else
		begin
			nmi_taken_r <= take_nmi;
			if (take_pin)
				nmi_cause_r <= CAUSE_NMI_PIN;
			else if (take_st)
				nmi_cause_r <= CAUSE_DBUS_ST;
			else if (take_ld)
				nmi_cause_r <= CAUSE_DBUS_LD;
		end
	end

	// One flop group per register; entry 0 is never written
	for (genvar i = 0; i <= GPR_COUNT; i++)
	begin : g_gpr
		always_ff @(posedge clk or negedge rst_n)
		begin
			if (!rst_n)
				gpr_r[i] <= GPR_W'(GPR_RST_VAL);
			else if (i != 0 && gpr_we && gpr_waddr == GPR_AW'(i))
				gpr_r[i] <= gpr_wdata;
		end
	end

	// Registered read costs a cycle but keeps the output a flop
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			gpr_rdata_r <= GPR_W'(GPR_RST_VAL);
		else
			gpr_rdata_r <= gpr_r[gpr_raddr];
	end

	// Outputs straight from flops
	assign fetch_valid   = fetch_valid_r;
	assign fetch_addr    = fetch_addr_r;
	assign nmi_taken     = nmi_taken_r;
	assign nmi_cause     = nmi_cause_r;
	assign err_addr_capt = err_addr_r;
	assign err_locked    = lock_r;
	assign gpr_rdata     = gpr_rdata_r;

endmodule : rnv_core_end

`default_nettype wire

// *** test/rnv_link_props.sv ***
`timescale 1ns/1ps
`default_nettype none

module rnv_link_props
	import rnv_pkg::*;
(
	// Clock and reset
	input wire logic             clk,
	input wire logic             resetn,
	// Link signals
	input wire logic             core_reset_n,
	input wire logic [VEC_W-1:0] boot_vec,
	input wire logic [VEC_W-1:0] nmi_vec,
	input wire logic             nmi_pin,
	// Core report
	input wire logic             fetch_valid,
	input wire logic [XLEN-1:0]  fetch_addr,
	input wire logic             nmi_taken,
	input wire logic [XLEN-1:0]  nmi_cause
);

	// One domain, so one clock and one disable
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	pin_high_min_a: assert property ($rose(nmi_pin) |=> nmi_pin)
		else $error("nmi pin high under two cycles");
	pin_low_min_a: assert property ($fell(nmi_pin) |=> !nmi_pin)
		else $error("nmi pin low under two cycles");
	rst_sync_hold_a: assert property ($rose(resetn) |-> !core_reset_n)
		else $error("core reset released with resetn");
	rst_release_a: assert property ($rose(resetn) |-> ##[1:3] core_reset_n)
		else $error("core reset not released");
	boot_fetch_a: assert property ($rose(core_reset_n) |=>
		fetch_valid && fetch_addr == {boot_vec, 1'b0})
		else $error("boot fetch missing or wrong");
	pin_nmi_a: assert property ($rose(nmi_pin) |-> ##4
		nmi_taken && nmi_cause == CAUSE_NMI_PIN && fetch_addr == {nmi_vec, 1'b0})
		else $error("pin nmi not taken in four cycles");
	nmi_pulse_a: assert property (nmi_taken && nmi_cause == CAUSE_NMI_PIN |=>
		!(nmi_taken && nmi_cause == CAUSE_NMI_PIN))
		else $error("pin nmi taken longer than one cycle");
	nmi_redirect_a: assert property (nmi_taken |-> fetch_valid)
		else $error("nmi taken without fetch redirect");

endmodule : rnv_link_props

`default_nettype wire

// *** test/reset_and_nmi_vector_logic_bench.sv ***
`timescale 1ns/1ps
`default_nettype none

`define CHK(n, e, a) \
	begin \
		check_count++; \
		if ((a) !== (e)) \
		begin \
			err_total++; \
			$display("[ERR] %s exp %0h got %0h", n, e, a); \
		end \
	end

module reset_and_nmi_vector_logic_bench;
	import rnv_pkg::*;

	localparam logic [VEC_W-1:0] BOOT_V = 31'h0002_0000;
	localparam logic [VEC_W-1:0] NMI_V  = 31'h0002_1000;
	localparam logic [VEC_W-1:0] BOOT_V2 = 31'h0003_0000;

	logic              clk, resetn, boot_vec_wr, nmi_vec_wr, nmi_fire, nmi_busy;
	logic              st_err, ld_err, unlock, gpr_we, fetch_valid, nmi_taken, err_locked;
	logic [VEC_W-1:0]  vec_wdata;
	logic [XLEN-1:0]   err_addr, gpr_wdata, gpr_rdata, fetch_addr, nmi_cause, err_capt;
	logic [XLEN-1:0]   cause_s, addr_s;
	logic [GPR_AW-1:0] gpr_waddr, gpr_raddr;
	logic              busy_off;
	int                err_total, check_count, hits, fhits;

	rnv_link_if link ();
	rnv_link_if link_off ();

	rnv_soc_end #(.BOOT_VEC_RST(BOOT_V)) rnv_soc_end_inst (.clk(clk), .resetn(resetn),
		.link(link), .boot_vec_wr(boot_vec_wr), .nmi_vec_wr(nmi_vec_wr),
		.vec_wdata(vec_wdata), .nmi_fire(nmi_fire), .nmi_busy(nmi_busy));

	// Second SoC end built without the pin feature; its pin must stay low
	rnv_soc_end #(.USE_NMI_PIN(1'b0)) rnv_soc_end_tied_inst (.clk(clk), .resetn(resetn),
		.link(link_off), .boot_vec_wr(boot_vec_wr), .nmi_vec_wr(nmi_vec_wr),
		.vec_wdata(vec_wdata), .nmi_fire(nmi_fire), .nmi_busy(busy_off));

	rnv_core_end rnv_core_end_inst (.clk(clk), .resetn(resetn), .link(link),
		.dbus_store_err(st_err), .dbus_load_err(ld_err), .dbus_err_addr(err_addr),
		.err_unlock_wr(unlock), .gpr_we(gpr_we), .gpr_waddr(gpr_waddr),
		.gpr_wdata(gpr_wdata), .gpr_raddr(gpr_raddr), .gpr_rdata(gpr_rdata),
		.fetch_valid(fetch_valid), .fetch_addr(fetch_addr), .nmi_taken(nmi_taken),
		.nmi_cause(nmi_cause), .err_addr_capt(err_capt), .err_locked(err_locked));

	rnv_link_props rnv_link_props_inst (.clk(clk), .resetn(resetn),
		.core_reset_n(link.core_reset_n), .boot_vec(link.boot_vec),
		.nmi_vec(link.nmi_vec), .nmi_pin(link.nmi_pin), .fetch_valid(fetch_valid),
		.fetch_addr(fetch_addr), .nmi_taken(nmi_taken), .nmi_cause(nmi_cause));

	// 10 MHz core clock
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task report_and_stop;
		if (err_total == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : report_and_stop

	// One-cycle strobe, launched at the falling edge
	task automatic pulse(ref logic s);
		@(negedge clk) s = 1'b1;
		@(negedge clk) s = 1'b0;
	endtask : pulse

	// Counts redirects; pulses stand one cycle, so every cycle is looked at
	task run(input int cyc);
		repeat (cyc)
		begin
			@(negedge clk);
			if (nmi_taken === 1'b1)
			begin
				hits++;
				cause_s = nmi_cause;
			end
			if (fetch_valid === 1'b1)
			begin
				fhits++;
				addr_s = fetch_addr;
			end
		end
	endtask : run

	task t_boot;
		hits = 0;
		fhits = 0;
		run(8);
		`CHK("boot_n", 1, fhits)
		`CHK("boot_addr", {BOOT_V, 1'b0}, addr_s)
		`CHK("gpr_rst", GPR_RST_VAL, gpr_rdata)
	endtask : t_boot

	task t_pin;
		vec_wdata = NMI_V;
		pulse(nmi_vec_wr);
		// Written boot vector shows on the link; the later reset restores the default
		vec_wdata = BOOT_V2;
		pulse(boot_vec_wr);
		`CHK("boot_vec_wr", BOOT_V2, link.boot_vec)
		hits = 0;
		repeat (2)
		begin
			pulse(nmi_fire);
			`CHK("pin_busy", 1'b1, nmi_busy)
			`CHK("pin_tied", 1'b0, link_off.nmi_pin)
			`CHK("tied_busy", 1'b0, busy_off)
			// Fire in the low phase is refused, else a second edge would follow
			@(negedge clk);
			pulse(nmi_fire);
			run(6);
			`CHK("pin_idle", 1'b0, nmi_busy)
		end
		`CHK("pin_n", 2, hits)
		`CHK("pin_cause", CAUSE_NMI_PIN, cause_s)
		`CHK("pin_addr", {NMI_V, 1'b0}, addr_s)
	endtask : t_pin

	task t_err;
		err_addr = 32'h1234_5678;
		hits = 0;
		pulse(st_err);
		run(4);
		`CHK("st_cause", CAUSE_DBUS_ST, cause_s)
		`CHK("st_capt", 32'h1234_5678, err_capt)
		`CHK("st_lock", 1'b1, err_locked)
		// Locked: a second error is gated but the pin still gets through
		err_addr = 32'h0000_00f0;
		pulse(ld_err);
		run(4);
		`CHK("gated_n", 1, hits)
		`CHK("gated_capt", 32'h1234_5678, err_capt)
		pulse(nmi_fire);
		run(6);
		`CHK("pin_locked", 2, hits)
		pulse(unlock);
		run(1);
		`CHK("unlocked", 1'b0, err_locked)
		pulse(ld_err);
		run(4);
		`CHK("ld_cause", CAUSE_DBUS_LD, cause_s)
		`CHK("ld_capt", 32'h0000_00f0, err_capt)
	endtask : t_err

	task t_gpr;
		@(negedge clk);
		gpr_we = 1'b1;
		gpr_waddr = 5'h03;
		gpr_wdata = 32'hcafe_0003;
		@(negedge clk);
		gpr_waddr = 5'h00;
		gpr_raddr = 5'h03;
		@(negedge clk);
		gpr_we = 1'b0;
		`CHK("gpr_x3", 32'hcafe_0003, gpr_rdata)
		gpr_raddr = 5'h00;
		@(negedge clk);
		`CHK("gpr_x0", GPR_RST_VAL, gpr_rdata)
		// Second reset mid-run: registers and lock must clear
		resetn = 1'b0;
		gpr_raddr = 5'h03;
		repeat (3) @(negedge clk);
		resetn = 1'b1;
		t_boot;
		`CHK("gpr_clr", GPR_RST_VAL, gpr_rdata)
		`CHK("lock_clr", 1'b0, err_locked)
	endtask : t_gpr

	// Whole run is about a hundred cycles
	initial
	begin
		#500000;
		err_total++;
		report_and_stop;
	end

	initial
	begin
		{resetn, boot_vec_wr, nmi_vec_wr, nmi_fire, st_err, ld_err, unlock, gpr_we} = '0;
		{vec_wdata, err_addr, gpr_wdata, gpr_waddr} = '0;
		gpr_raddr = 5'h05;
		err_total = 0;
		check_count = 0;
		repeat (20) @(negedge clk);
		resetn = 1'b1;
		t_boot;
		t_pin;
		t_err;
		t_gpr;
		report_and_stop;
	end

endmodule : reset_and_nmi_vector_logic_bench

`default_nettype wire
